// *** hw/aec_pkg.sv ***
/*
 Constants for the axis error compensation and park block: parameter
 selectors, field positions, table geometry, display codes.
 Assumes one synchronous clock domain and a service-channel style
 parameter port driven by the ring master.
*/
// Function
// - Two correction tables, one per travel direction, 500 entries each.
// - Every correction entry is a 16-bit value.
// - Start position is the negative end and smallest value of the range.
// - One constant spacing applies between all compensation points.
// - Entries 1-500 for positive velocity, 501-1000 for negative velocity.
// - Feedback outside the correction range passes through uncorrected.
// - Tables are written over the ring and kept in nonvolatile storage.
// - All compensation data in preferred scaling, corrections within 3.27 mm.
// - Drive-controlled homing is not run while inside the correction range.
// - Compensation is enabled only when control bit 0 is one.
// - Initialization checks parameters, sets status bits, clears enable bit on a failed check.
// - Tables appear as one variable-length list of 2-byte elements.
// - Spacing and start position are 32-bit preferred scaling values.
// - Decoupling suppresses error reports to controller and supply module.
// - While decoupled, display shows the decoupled symbol, controller stays off.
package aec_pkg;
   // ----------------------------------------------------------------
   // Table geometry
   // ----------------------------------------------------------------
   localparam int ENTRIES = 500;
   localparam int TABLES = 2;
   localparam int TOTAL = ENTRIES * TABLES;
   localparam int ENTRY_W = 16;
   localparam int POS_W = 32;
   localparam int IDX_W = 10;
   localparam logic [IDX_W-1:0] NEG_BASE = 10'h1f4;
   localparam logic [IDX_W-1:0] POS_LAST = 10'h1f3;
   localparam logic [IDX_W-1:0] NEG_LAST = 10'h3e7;
   localparam logic [47:0] LAST_SEG = 48'h0000_0000_01f3;
   localparam int DIV_W = 48;
   localparam logic [5:0] DIV_STEPS = 6'h30;
   // ----------------------------------------------------------------
   // Parameter selectors
   // ----------------------------------------------------------------
   localparam logic [2:0] SEL_CTL = 3'h0;
   localparam logic [2:0] SEL_START = 3'h1;
   localparam logic [2:0] SEL_SPACING = 3'h2;
   localparam logic [2:0] SEL_TABLE = 3'h3;
   localparam logic [2:0] SEL_PARK = 3'h4;
   localparam logic [2:0] SEL_LEN = 3'h5;
   localparam logic [31:0] LIST_BYTES = 32'h0000_07d0;
   // ----------------------------------------------------------------
   // Control and status fields
   // ----------------------------------------------------------------
   localparam int CTL_EN = 0;
   localparam int ST_SPACING = 1;
   localparam int ST_TABLE = 2;
   localparam int PARK_BIT = 0;
   localparam logic [2:0] PHASE_PARAM = 3'h2;
   // Spacing ceiling in feedback units equal to 1450 degrees at the shaft
   localparam logic [31:0] SPACING_LIMIT_DEF = 32'h0000_05aa;
   // ----------------------------------------------------------------
   // Display codes
   // ----------------------------------------------------------------
   localparam logic [7:0] DISP_IDLE = 8'h00;
   localparam logic [7:0] DISP_RUN = 8'h01;
   localparam logic [7:0] DISP_DECOUPLED = 8'h50;
   typedef enum logic [2:0] {ST_IDLE, ST_DIV1, ST_FETCH, ST_DIV2, ST_DONE} aec_state_t;
endpackage : aec_pkg

// *** hw/aec_top.sv ***
/*
 Axis error compensation with direction dependent tables, parameter
 check at initialization, and the axis decoupling (park) command.
 Assumes the ring interface hands over parameter accesses one at a
 time on the param_* port and that all inputs are synchronous.
*/
`timescale 1ns/10ps
module aec_top #(
   parameter logic [31:0] SPACING_LIMIT = aec_pkg::SPACING_LIMIT_DEF
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [2:0] comm_phase,
   input wire logic [2:0] param_sel,
   input wire logic [aec_pkg::IDX_W-1:0] param_index,
   input wire logic param_wr,
   input wire logic param_rd,
   input wire logic [31:0] param_wdata,
   output logic [31:0] param_rdata,
   output logic param_ack,
   input wire logic init_req,
   input wire logic feedback_valid,
   input wire logic signed [aec_pkg::POS_W-1:0] feedback_pos,
   input wire logic signed [31:0] cmd_velocity,
   output logic signed [aec_pkg::POS_W-1:0] corrected_pos,
   output logic corrected_valid,
   output logic in_range,
   input wire logic drive_on_cmd,
   input wire logic drive_fault,
   output logic drive_ctrl_active,
   output logic err_to_nc,
   output logic err_to_psu,
   output logic [7:0] status_display,
   input wire logic homing_req,
   output logic homing_start,
   output logic homing_refused,
   output logic nvm_wr,
   output logic [aec_pkg::IDX_W-1:0] nvm_addr,
   output logic [aec_pkg::ENTRY_W-1:0] nvm_data
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Both tables in one list, positive half first
   logic [aec_pkg::ENTRY_W-1:0] table_mem [0:aec_pkg::TOTAL-1];
   logic [31:0] start_reg;
   logic [31:0] spacing_value_reg;
   logic [15:0] ctl_reg;
   logic park_reg;

   // ----------------------------------------------------------------
   // Parameter port decode
   // ----------------------------------------------------------------
   wire logic wr_ctl = param_wr && (param_sel == aec_pkg::SEL_CTL);
   wire logic wr_start = param_wr && (param_sel == aec_pkg::SEL_START);
   wire logic wr_spacing = param_wr && (param_sel == aec_pkg::SEL_SPACING);
   wire logic wr_park = param_wr && (param_sel == aec_pkg::SEL_PARK);
   wire logic idx_ok = param_index < aec_pkg::IDX_W'(aec_pkg::TOTAL);
   wire logic wr_table = param_wr && (param_sel == aec_pkg::SEL_TABLE) && idx_ok;
   wire logic [aec_pkg::ENTRY_W-1:0] rd_entry = idx_ok ? table_mem[param_index] : 16'h0000;

   // Read data selection; unknown selectors read zero
   logic [31:0] rdata_next;
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      unique case (param_sel)
         aec_pkg::SEL_CTL: rdata_next = {16'h0000, ctl_reg};
         aec_pkg::SEL_START: rdata_next = start_reg;
         aec_pkg::SEL_SPACING: rdata_next = spacing_value_reg;
         aec_pkg::SEL_TABLE: rdata_next = {16'h0000, rd_entry};
         aec_pkg::SEL_PARK: rdata_next = {31'h0000_0000, park_reg};
         aec_pkg::SEL_LEN: rdata_next = aec_pkg::LIST_BYTES;
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // Answer one cycle after each access, mirror table writes, range parameters
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         param_rdata <= 32'h0000_0000;
         param_ack <= 1'b0;
         nvm_wr <= 1'b0;
         nvm_addr <= '0;
         nvm_data <= '0;
         start_reg <= 32'h0000_0000;
         spacing_value_reg <= 32'h0000_0000;
      end
      else
      begin
         param_rdata <= rdata_next;
         param_ack <= param_wr || param_rd;
         nvm_wr <= wr_table;
         nvm_addr <= param_index;
         nvm_data <= param_wdata[aec_pkg::ENTRY_W-1:0];
         if (wr_start)
            start_reg <= param_wdata;
         if (wr_spacing)
            spacing_value_reg <= param_wdata;
      end
   end

   // Table writes; the array stands for the programming module store
   always_ff @(posedge sys_clk)
   begin
      if (wr_table)
      begin
         table_mem[param_index] <= param_wdata[aec_pkg::ENTRY_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Initialization check and control word
   // ----------------------------------------------------------------
   wire logic spacing_bad = (spacing_value_reg == 32'h0000_0000)
      || (spacing_value_reg > SPACING_LIMIT);
   wire logic table_bad = (table_mem[0] != 16'h0000)
      || (table_mem[aec_pkg::POS_LAST] != 16'h0000)
      || (table_mem[aec_pkg::NEG_BASE] != 16'h0000)
      || (table_mem[aec_pkg::NEG_LAST] != 16'h0000);
   wire logic chk_spacing = init_req && spacing_bad;
   wire logic chk_table = init_req && table_bad;
   wire logic en_clear = chk_spacing || chk_table;
   wire logic comp_en = ctl_reg[aec_pkg::CTL_EN];

   // Enable bit written by master; status bits are write-one-to-clear
   logic [15:0] ctl_next;
   always_comb
   begin
      ctl_next = ctl_reg;
      if (wr_ctl)
      begin
         ctl_next[aec_pkg::CTL_EN] = param_wdata[aec_pkg::CTL_EN];
         if (param_wdata[aec_pkg::ST_SPACING])
            ctl_next[aec_pkg::ST_SPACING] = 1'b0;
         if (param_wdata[aec_pkg::ST_TABLE])
            ctl_next[aec_pkg::ST_TABLE] = 1'b0;
      end
      // Set by the check wins over a clear in the same cycle
      if (chk_spacing)
         ctl_next[aec_pkg::ST_SPACING] = 1'b1;
      if (chk_table)
         ctl_next[aec_pkg::ST_TABLE] = 1'b1;
      if (en_clear)
         ctl_next[aec_pkg::CTL_EN] = 1'b0;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         ctl_reg <= 16'h0000;
      else
         ctl_reg <= ctl_next;
   end

   // ----------------------------------------------------------------
   // Park command
   // ----------------------------------------------------------------
   // Accepted only in the parameter phase; reset of the command anytime
   wire logic park_set = wr_park && param_wdata[aec_pkg::PARK_BIT]
      && (comm_phase == aec_pkg::PHASE_PARAM);
   wire logic park_clr = wr_park && !param_wdata[aec_pkg::PARK_BIT];

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         park_reg <= 1'b0;
      else if (park_set)
         park_reg <= 1'b1;
      else if (park_clr)
         park_reg <= 1'b0;
   end

   // Drive state, error forwarding and display
   logic [7:0] disp_next;
   assign disp_next = park_reg ? aec_pkg::DISP_DECOUPLED :
      (drive_on_cmd ? aec_pkg::DISP_RUN : aec_pkg::DISP_IDLE);

   // ----------------------------------------------------------------
   // Correction pipeline
   // ----------------------------------------------------------------
   localparam int DW = aec_pkg::DIV_W;
   aec_pkg::aec_state_t state_reg;
   logic signed [31:0] pos_reg;
   logic neg_dir_reg;
   logic [DW-1:0] num_reg;
   logic [31:0] den_reg;
   logic [32:0] rem_reg;
   logic [5:0] cnt_reg;
   logic [31:0] frac_reg;
   logic [aec_pkg::IDX_W-1:0] idx_reg;
   logic signed [16:0] e0_reg;
   logic signed [16:0] diff_reg;
   logic prod_neg_reg;
   logic signed [16:0] corr_reg;
   logic in_rng_reg;

   // Offset from the table start; negative means below the range
   wire logic signed [32:0] offset = {pos_reg[31], pos_reg} - {start_reg[31], start_reg};
   wire logic below = offset[32];
   // Restoring divider step
   wire logic [32:0] rem_shift = {rem_reg[31:0], num_reg[DW-1]};
   wire logic rem_ge = rem_shift >= {1'b0, den_reg};
   wire logic [32:0] rem_step = rem_ge ? (rem_shift - {1'b0, den_reg}) : rem_shift;
   wire logic [DW-1:0] num_step = {num_reg[DW-2:0], rem_ge};
   wire logic div_last = cnt_reg == (aec_pkg::DIV_STEPS - 6'h01);
   // Segment index and fraction after the first division
   wire logic seg_out = num_step >= aec_pkg::LAST_SEG;
   wire logic [aec_pkg::IDX_W-1:0] seg_idx = num_step[aec_pkg::IDX_W-1:0];
   wire logic [aec_pkg::IDX_W-1:0] base = neg_dir_reg ? aec_pkg::NEG_BASE : '0;
   wire logic [aec_pkg::IDX_W-1:0] idx0 = base + idx_reg;
   wire logic [aec_pkg::IDX_W-1:0] idx1 = idx0 + 10'h001;
   wire logic signed [16:0] ent0 = {table_mem[idx0][15], table_mem[idx0]};
   wire logic signed [16:0] ent1 = {table_mem[idx1][15], table_mem[idx1]};
   wire logic signed [16:0] ent_diff = 17'(ent1 - ent0);
   wire logic [15:0] diff_mag = 16'(diff_reg[16] ? -diff_reg : diff_reg);
   wire logic [47:0] prod_mag = {16'h0000, frac_reg} * {32'h0000_0000, diff_mag};
   // Interpolated correction once the second division ends
   wire logic signed [16:0] step_s = 17'({1'b0, num_step[15:0]});
   wire logic signed [16:0] interp = 17'(prod_neg_reg ? (e0_reg - step_s) : (e0_reg + step_s));
   wire logic signed [32:0] sum = {pos_reg[31], pos_reg} + {{16{corr_reg[16]}}, corr_reg};
   wire logic start_ok = comp_en && (spacing_value_reg != 32'h0000_0000);

   // Sequencer: divide offset by spacing, fetch, divide slope term
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= aec_pkg::ST_IDLE;
         pos_reg <= '0;
         neg_dir_reg <= 1'b0;
         num_reg <= '0;
         den_reg <= '0;
         rem_reg <= '0;
         cnt_reg <= '0;
         frac_reg <= '0;
         idx_reg <= '0;
         e0_reg <= '0;
         diff_reg <= '0;
         prod_neg_reg <= 1'b0;
         corr_reg <= '0;
         in_rng_reg <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            aec_pkg::ST_IDLE:
            begin
               corr_reg <= '0;
               if (feedback_valid)
               begin
                  pos_reg <= feedback_pos;
                  neg_dir_reg <= cmd_velocity[31];
                  in_rng_reg <= 1'b0;
                  state_reg <= aec_pkg::ST_DIV1;
               end
            end
            aec_pkg::ST_DIV1:
            begin
               if (cnt_reg == 6'h00 && num_reg == '0 && rem_reg == '0 && den_reg == '0)
               begin
                  // First cycle: load or bypass
                  if (!start_ok || below)
                     state_reg <= aec_pkg::ST_DONE;
                  else
                  begin
                     num_reg <= {16'h0000, offset[31:0]};
                     den_reg <= spacing_value_reg;
                  end
               end
               else
               begin
                  num_reg <= num_step;
                  rem_reg <= rem_step;
                  cnt_reg <= cnt_reg + 6'h01;
                  if (div_last)
                  begin
                     cnt_reg <= '0;
                     rem_reg <= '0;
                     num_reg <= '0;
                     frac_reg <= rem_step[31:0];
                     idx_reg <= seg_idx;
                     in_rng_reg <= !seg_out;
                     state_reg <= seg_out ? aec_pkg::ST_DONE : aec_pkg::ST_FETCH;
                  end
               end
            end
            aec_pkg::ST_FETCH:
            begin
               e0_reg <= ent0;
               diff_reg <= ent_diff;
               state_reg <= aec_pkg::ST_DIV2;
            end
            aec_pkg::ST_DIV2:
            begin
               if (cnt_reg == 6'h00 && rem_reg == '0 && num_reg == '0)
               begin
                  num_reg <= prod_mag;
                  prod_neg_reg <= diff_reg[16];
                  if (prod_mag == '0)
                  begin
                     corr_reg <= e0_reg;
                     state_reg <= aec_pkg::ST_DONE;
                  end
               end
               else
               begin
                  num_reg <= num_step;
                  rem_reg <= rem_step;
                  cnt_reg <= cnt_reg + 6'h01;
                  if (div_last)
                  begin
                     cnt_reg <= '0;
                     rem_reg <= '0;
                     num_reg <= '0;
                     corr_reg <= interp;
                     state_reg <= aec_pkg::ST_DONE;
                  end
               end
            end
            aec_pkg::ST_DONE:
            begin
               den_reg <= '0;
               state_reg <= aec_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Result ready in the closing state
   wire logic done_now = state_reg == aec_pkg::ST_DONE;
   // Drive gating, display, result, range flag; homing refused inside the range
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         drive_ctrl_active <= 1'b0;
         err_to_nc <= 1'b0;
         err_to_psu <= 1'b0;
         status_display <= aec_pkg::DISP_IDLE;
         corrected_pos <= '0;
         corrected_valid <= 1'b0;
         in_range <= 1'b0;
         homing_start <= 1'b0;
         homing_refused <= 1'b0;
      end
      else
      begin
         drive_ctrl_active <= drive_on_cmd && !park_reg;
         err_to_nc <= drive_fault && !park_reg;
         err_to_psu <= drive_fault && !park_reg;
         status_display <= disp_next;
         homing_start <= homing_req && !in_range && !park_reg;
         homing_refused <= homing_req && (in_range || park_reg);
         corrected_valid <= done_now;
         if (done_now)
         begin
            corrected_pos <= sum[31:0];
            in_range <= in_rng_reg;
         end
      end
   end
endmodule : aec_top

// *** test/aec_nc_master.sv ***
/*
 NC master model: parameter accesses and the axis park sequence.
 Assumes aec_top answers each access with param_ack.
*/
`timescale 1ns/10ps
module aec_nc_master (
   input wire logic sys_clk,
   input wire logic param_ack,
   input wire logic [31:0] param_rdata,
   output logic [2:0] comm_phase = 3'h4,
   output logic [2:0] param_sel = 3'h0,
   output logic [9:0] param_index = 10'h0,
   output logic param_wr = 1'b0,
   output logic param_rd = 1'b0,
   output logic [31:0] param_wdata = 32'h0,
   output logic drive_on_cmd = 1'b0
);
   // ----------------------------------------------------------------
   // Master tasks
   // ----------------------------------------------------------------
   // One access: pulse at a falling edge, answer awaited three cycles
   task access(input logic wr, input logic [2:0] sel, input logic [9:0] idx,
      input logic [31:0] d, output logic [31:0] rd, output bit ok);
      ok = 1'b0;
      rd = 32'h0;
      @(negedge sys_clk);
      param_sel = sel;
      param_index = idx;
      param_wdata = d;
      param_wr = wr;
      param_rd = !wr;
      for (int i = 0; i < 3 && !ok; i++)
      begin
         @(negedge sys_clk);
         param_wr = 1'b0;
         param_rd = 1'b0;
         param_wdata = ~d;  // Released data stops showing the last value
         ok = param_ack === 1'b1;
         rd = param_rdata;
      end
   endtask : access
   // Decouple or recouple the axis from the parametrizing phase
   task park(input logic on);
      logic [31:0] rd;
      bit ok;
      drive_on_cmd = 1'b0;
      comm_phase = aec_pkg::PHASE_PARAM;
      access(1'b1, aec_pkg::SEL_PARK, 10'h0, {31'h0, on}, rd, ok);
      comm_phase = 3'h4;
   endtask : park
endmodule : aec_nc_master

// *** test/aec_top_assertions.sv ***
/*
 Checker for aec_top: parameter port timing, table store, park gating.
 Assumes it is bound to aec_top and sees only that module's ports.
*/
`timescale 1ns/10ps
module aec_top_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [2:0] comm_phase,
   input wire logic [2:0] param_sel,
   input wire logic [aec_pkg::IDX_W-1:0] param_index,
   input wire logic param_wr,
   input wire logic param_rd,
   input wire logic [31:0] param_wdata,
   input wire logic [31:0] param_rdata,
   input wire logic param_ack,
   input wire logic drive_fault,
   input wire logic err_to_nc,
   input wire logic err_to_psu,
   input wire logic drive_ctrl_active,
   input wire logic [7:0] status_display,
   input wire logic nvm_wr,
   input wire logic [aec_pkg::IDX_W-1:0] nvm_addr,
   input wire logic [aec_pkg::ENTRY_W-1:0] nvm_data
);
   // ----------------------------------------------------------------
   // Port properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Decoded request kinds
   wire tbl_wr = param_wr && param_sel == aec_pkg::SEL_TABLE && param_index < 10'h3e8;
   wire park_wr = param_wr && param_sel == aec_pkg::SEL_PARK && param_wdata[aec_pkg::PARK_BIT];
   wire parked = status_display == aec_pkg::DISP_DECOUPLED;
   sequence s_parked_later;
      ##2 parked;
   endsequence
   sequence s_stays_free;
      ##1 !parked [*2];
   endsequence
   a_ack_follows:
   assert property ((param_wr || param_rd) |=> param_ack)
      else $error("access without acknowledge");
   a_nvm_store:
   assert property (tbl_wr |=> nvm_wr && nvm_addr == $past(param_index)
      && nvm_data == $past(param_wdata[aec_pkg::ENTRY_W-1:0]))
      else $error("table write not stored");
   a_nvm_cause:
   assert property (nvm_wr |-> $past(tbl_wr))
      else $error("store without valid table write");
   a_list_length:
   assert property ((param_rd && param_sel == aec_pkg::SEL_LEN) |=> param_rdata == aec_pkg::LIST_BYTES)
      else $error("list length wrong");
   a_park_enter:
   assert property ((park_wr && comm_phase == aec_pkg::PHASE_PARAM) |-> s_parked_later)
      else $error("park not shown");
   a_park_refuse:
   assert property ((park_wr && comm_phase != aec_pkg::PHASE_PARAM && !parked) |-> s_stays_free)
      else $error("park taken outside phase two");
   a_park_quiet:
   assert property (parked |-> !err_to_nc && !err_to_psu && !drive_ctrl_active)
      else $error("parked drive not quiet");
   a_err_pair:
   assert property (err_to_nc |-> err_to_psu && $past(drive_fault))
      else $error("error report without fault");
endmodule : aec_top_chk
bind aec_top aec_top_chk i_chk (.sys_clk, .rst, .comm_phase, .param_sel, .param_index,
   .param_wr, .param_rd, .param_wdata, .param_rdata, .param_ack, .drive_fault, .err_to_nc,
   .err_to_psu, .drive_ctrl_active, .status_display, .nvm_wr, .nvm_addr, .nvm_data);

// *** test/tb_axis_error_compensation_park.sv ***
/*
 Self-checking bench for aec_top against a model of the correction rules.
 Assumes the NC master model drives the parameter port and ring phase.
*/
`timescale 1ns/10ps
module tb_axis_error_compensation_park;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic init_req = 1'b0, feedback_valid = 1'b0, drive_fault = 1'b0, homing_req = 1'b0;
   logic signed [31:0] feedback_pos = 32'sh0, cmd_velocity = 32'sh0, corrected_pos;
   logic [2:0] comm_phase, param_sel;
   logic [9:0] param_index, nvm_addr;
   logic [31:0] param_wdata, param_rdata, rv, lf = 32'h31d92dee;
   logic [15:0] nvm_data;
   logic [7:0] status_display;
   logic param_wr, param_rd, param_ack, drive_on_cmd, corrected_valid, in_range, nvm_wr;
   logic drive_ctrl_active, err_to_nc, err_to_psu, homing_start, homing_refused;
   logic [31:0] sp_tab [4] = '{32'h0, aec_pkg::SPACING_LIMIT_DEF + 32'h1, 32'd100, 32'd100};
   longint offs [4] = '{-1, 0, 49899, 49900};
   int err_count = 0, compares = 0, tbl [1000];
   longint start_v = 0, spc = 100;
   bit en = 1'b1;
   // ----------------------------------------------------------------
   // Design, master model, clock
   // ----------------------------------------------------------------
   aec_top i_dut (.sys_clk, .rst, .comm_phase, .param_sel, .param_index, .param_wr, .param_rd,
      .param_wdata, .param_rdata, .param_ack, .init_req, .feedback_valid, .feedback_pos,
      .cmd_velocity, .corrected_pos, .corrected_valid, .in_range, .drive_on_cmd, .drive_fault,
      .drive_ctrl_active, .err_to_nc, .err_to_psu, .status_display, .homing_req, .homing_start,
      .homing_refused, .nvm_wr, .nvm_addr, .nvm_data);
   aec_nc_master i_nc (.sys_clk, .param_ack, .param_rdata, .comm_phase, .param_sel,
      .param_index, .param_wr, .param_rd, .param_wdata, .drive_on_cmd);
   // Clock of 100 ns period
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end
   // Verdict and end of run
   task final_report;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // Compare one value and count it
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One parameter access, read data left in rv; a lost answer ends the run
   task acc(input logic wr, input logic [2:0] sel, input logic [9:0] idx, input logic [31:0] d);
      bit ok;
      i_nc.access(wr, sel, idx, d, rv, ok);
      if (!ok)
      begin
         err_count++;
         final_report();
      end
   endtask : acc
   // Step of the bench generator
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   // Expected corrected position
   function automatic logic [31:0] model(input longint pos, input bit neg);
      longint off, q, r, d, c;
      off = pos - start_v;
      if (!en || off < 0)
         return 32'(pos);
      q = off / spc;
      r = off % spc;
      if (q >= 499)
         return 32'(pos);
      q = neg ? q + 500 : q;
      d = tbl[q + 1] - tbl[q];
      c = tbl[q] + (d < 0 ? -((-d) * r / spc) : d * r / spc);
      return 32'(pos + c);
   endfunction : model
   // Feed one sample with a random velocity and compare the result
   task sample(input longint off);
      int i;
      @(negedge sys_clk);
      lf = nxt(lf);
      feedback_pos = 32'(start_v + off);
      cmd_velocity = lf;
      feedback_valid = 1'b1;
      @(negedge sys_clk);
      feedback_valid = 1'b0;
      for (i = 0; i < 120 && corrected_valid !== 1'b1; i++)
         @(negedge sys_clk);
      check(corrected_pos, model(start_v + off, lf[31]));
      if (i == 120)
      begin
         err_count++;
         final_report();
      end
   endtask : sample
   // Gated drive outputs after they settle
   task gates(input logic [10:0] exp);
      repeat (3) @(negedge sys_clk);
      check({21'h0, drive_ctrl_active, err_to_nc, err_to_psu, status_display}, {21'h0, exp});
   endtask : gates
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         if (k != 3 && k != 4)
         begin
            acc(1'b0, 3'(k), 10'h0, 32'h0);
            check(rv, k == 5 ? aec_pkg::LIST_BYTES : 32'h0);
         end
      end
      $display("test reset done");
      for (int k = 0; k < 1000; k++)
      begin
         lf = nxt(lf);
         tbl[k] = (k % 500 == 0 || k % 500 >= 480) ? 0 : int'(lf % 81) - 40;
         acc(1'b1, aec_pkg::SEL_TABLE, 10'(k), 32'(tbl[k]));
      end
      acc(1'b1, aec_pkg::SEL_TABLE, 10'd1000, 32'h1234);
      acc(1'b0, aec_pkg::SEL_TABLE, 10'd1000, 32'h0);
      check(rv, 32'h0);
      for (int k = 0; k < 8; k++)
      begin
         lf = nxt(lf);
         acc(1'b0, aec_pkg::SEL_TABLE, 10'(lf % 1000), 32'h0);
         check({16'h0, rv[15:0]}, {16'h0, 16'(tbl[lf % 1000])});
      end
      $display("test tables done");
      for (int k = 0; k < 4; k++)
      begin
         acc(1'b1, aec_pkg::SEL_SPACING, 10'h0, sp_tab[k]);
         acc(1'b1, aec_pkg::SEL_TABLE, 10'h1f4, k == 2 ? 32'h7 : 32'h0);
         acc(1'b1, aec_pkg::SEL_CTL, 10'h0, 32'h7);
         init_req = 1'b1;
         @(negedge sys_clk);
         init_req = 1'b0;
         acc(1'b0, aec_pkg::SEL_CTL, 10'h0, 32'h0);
         check(rv & 32'h7, k == 3 ? 32'h1 : k == 2 ? 32'h4 : 32'h2);
      end
      $display("test init done");
      start_v = longint'(lf[15:0]);
      acc(1'b1, aec_pkg::SEL_START, 10'h0, 32'(start_v));
      acc(1'b0, aec_pkg::SEL_START, 10'h0, 32'h0);
      check(rv, 32'(start_v));
      foreach (offs[k])
         sample(offs[k]);
      for (int k = 0; k < 12; k++)
         sample(longint'(nxt(lf) % 52000) - 1000);
      for (int k = 0; k < 2; k++)
      begin
         sample(k ? 0 : 49900);
         homing_req = 1'b1;
         @(negedge sys_clk);
         homing_req = 1'b0;
         check({29'h0, in_range, homing_start, homing_refused}, k ? 32'h5 : 32'h2);
      end
      acc(1'b1, aec_pkg::SEL_CTL, 10'h0, 32'h0);
      en = 1'b0;
      sample(100);
      $display("test correction done");
      i_nc.drive_on_cmd = 1'b1;
      drive_fault = 1'b1;
      gates({3'b111, aec_pkg::DISP_RUN});
      acc(1'b1, aec_pkg::SEL_PARK, 10'h0, 32'h1);
      gates({3'b111, aec_pkg::DISP_RUN});
      i_nc.park(1'b1);
      gates({3'b000, aec_pkg::DISP_DECOUPLED});
      i_nc.park(1'b0);
      i_nc.drive_on_cmd = 1'b1;
      gates({3'b111, aec_pkg::DISP_RUN});
      $display("test park done");
      final_report();
   end
endmodule : tb_axis_error_compensation_park
